/* File: src/mwt_wave_table.sv */
/*
 * microstep wave table: upper delta words, start and segment registers
 * on an ahb-lite slave, and a walker that rebuilds both coil currents.
 * assumes: one clock hclk, async active-low hresetn, lower 192 delta
 * bits supplied by a neighbouring block, step and restart pulses
 * synchronous to hclk.
 */
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "mwt_consts.svh"

module mwt_wave_table (
    // clock and reset
    input  wire  logic              hclk,
    input  wire  logic              hresetn,
    // ahb-lite slave
    input  wire  logic              hsel,
    input  wire  logic [31:0]       haddr,
    input  wire  logic [1:0]        htrans,
    input  wire  logic              hwrite,
    input  wire  logic [2:0]        hsize,
    input  wire  logic [31:0]       hwdata,
    input  wire  logic              hready,
    output var   logic              hreadyout,
    output var   logic              hresp,
    output var   logic [31:0]       hrdata,
    // lower table words and walker control
    input  wire  logic [191:0]      lower_delta_bits,
    input  wire  logic              step_advance,
    input  wire  logic              restart,
    // coil outputs
    output var   mwt_pkg::mwt_cur_t coil_a_current,
    output var   mwt_pkg::mwt_cur_t coil_b_current,
    output var   mwt_pkg::mwt_pos_t table_index,
    output var   mwt_pkg::mwt_pos_t coil_b_position
);
    import mwt_pkg::*;

    // ************************************************************
    // decode functions
    // ************************************************************
    function automatic mwt_reg_t reg_decode(input logic [31:0] addr,
                                            input logic [2:0] size);
        mwt_reg_t r;
        r = MWT_R_NONE;
        if (addr[31:10] == 22'h0 && addr[1:0] == 2'h0 && size == `MWT_HSIZE_WORD) begin
            unique case (addr[9:2])
                `MWT_IDX_SIX:   r = MWT_R_SIX;
                `MWT_IDX_SEVEN: r = MWT_R_SEVEN;
                `MWT_IDX_START: r = MWT_R_START;
                `MWT_IDX_SEL:   r = MWT_R_SEL;
                default:        r = MWT_R_NONE;
            endcase
        end
        return r;
    endfunction : reg_decode

    // result of undefined boundary order is simply first match
    function automatic mwt_width_t width_of(input logic [7:0] e,
                                            input logic [31:0] s);
        mwt_width_t w;
        if (e < s[`MWT_BND1_LSB +: 8]) begin
            w = s[`MWT_W0_LSB +: 2];
        end else if (e < s[`MWT_BND2_LSB +: 8]) begin
            w = s[`MWT_W1_LSB +: 2];
        end else if (e < s[`MWT_BND3_LSB +: 8]) begin
            w = s[`MWT_W2_LSB +: 2];
        end else begin
            w = s[`MWT_W3_LSB +: 2];
        end
        return w;
    endfunction : width_of

    // difference w - 1 + bit, three-bit two's complement
    function automatic logic [2:0] delta_of(input logic b,
                                            input mwt_width_t w);
        return 3'({1'b0, w}) - 3'h1 + 3'({2'h0, b});
    endfunction : delta_of

    // ************************************************************
    // register file and bus
    // ************************************************************
    logic [31:0] delta_bits_word_six;
    logic [31:0] delta_bits_word_seven;
    logic [31:0] wave_start_values;
    logic [31:0] segment_width_config;
    logic        wr_pend;
    mwt_reg_t    wr_reg;
    logic [31:0] next_six;
    logic [31:0] next_seven;
    logic [31:0] next_start;
    logic [31:0] next_sel;
    logic        next_wr_pend;
    mwt_reg_t    next_wr_reg;
    logic [31:0] next_hrdata;
    logic        bus_take;
    mwt_reg_t    addr_reg;

    always_comb begin
        bus_take     = hsel && hready && htrans[1];
        addr_reg     = reg_decode(haddr, hsize);
        next_wr_pend = bus_take && hwrite;
        next_wr_reg  = addr_reg;
        next_six     = delta_bits_word_six;
        next_seven   = delta_bits_word_seven;
        next_start   = wave_start_values;
        next_sel     = segment_width_config;
        next_hrdata  = hrdata;
        if (wr_pend) begin
            unique case (wr_reg)
                MWT_R_SIX:   next_six   = hwdata;
                MWT_R_SEVEN: next_seven = hwdata;
                MWT_R_START: next_start = hwdata & `MWT_START_MASK;
                MWT_R_SEL:   next_sel   = hwdata;
                MWT_R_NONE:  next_sel   = segment_width_config;
            endcase
        end
        // read from next values so a finishing write is seen
        if (bus_take && !hwrite) begin
            unique case (addr_reg)
                MWT_R_SIX:   next_hrdata = next_six;
                MWT_R_SEVEN: next_hrdata = next_seven;
                MWT_R_START: next_hrdata = next_start;
                MWT_R_SEL:   next_hrdata = next_sel;
                MWT_R_NONE:  next_hrdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            delta_bits_word_six   <= `MWT_RST_SIX;
            delta_bits_word_seven <= `MWT_RST_SEVEN;
            wave_start_values     <= `MWT_RST_START;
            segment_width_config  <= `MWT_RST_SEL;
            wr_pend               <= 1'b0;
            wr_reg                <= MWT_R_NONE;
            hrdata                <= 32'h0000_0000;
            hreadyout             <= 1'b0;
            hresp                 <= 1'b0;
        end else begin
            delta_bits_word_six   <= next_six;
            delta_bits_word_seven <= next_seven;
            wave_start_values     <= next_start;
            segment_width_config  <= next_sel;
            wr_pend               <= next_wr_pend;
            wr_reg                <= next_wr_reg;
            hrdata                <= next_hrdata;
            hreadyout             <= 1'b1;
            hresp                 <= 1'b0;
        end
    end

    // ************************************************************
    // table walker
    // ************************************************************
    logic [255:0] table_bits;
    mwt_cur_t     next_a;
    mwt_cur_t     next_b;
    mwt_pos_t     next_idx;
    mwt_pos_t     next_bpos;
    logic [7:0]   a_ent;
    logic [7:0]   b_ent;
    logic [2:0]   a_delta;
    logic [2:0]   b_delta;
    logic [7:0]   ofs;

    always_comb begin
        table_bits = {delta_bits_word_seven, delta_bits_word_six, lower_delta_bits};
        ofs        = wave_start_values[`MWT_OFFSET_LSB +: 8];
        a_ent      = table_index[7:0];
        // coil b walks down from entry 255 over mirrored entries
        b_ent      = ~table_index[7:0];
        a_delta    = delta_of(table_bits[a_ent], width_of(a_ent, segment_width_config));
        b_delta    = delta_of(table_bits[b_ent], width_of(b_ent, segment_width_config));
        next_a     = coil_a_current;
        next_b     = coil_b_current;
        next_idx   = table_index;
        if (restart) begin
            next_idx = 9'h000;
            next_a   = wave_start_values[`MWT_START_A_LSB +: 8];
            next_b   = wave_start_values[`MWT_START_B_LSB +: 8];
        end else if (step_advance && table_index != `MWT_LAST_POS) begin
            next_idx = 9'(table_index + 9'h001);
            next_a   = 8'(coil_a_current + {{5{a_delta[2]}}, a_delta});
            next_b   = 8'(coil_b_current - {{5{b_delta[2]}}, b_delta});
        end
        next_bpos = 9'(next_idx + {ofs[7], ofs});
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            coil_a_current  <= `MWT_RST_COIL_A;
            coil_b_current  <= `MWT_RST_COIL_B;
            table_index     <= 9'h000;
            coil_b_position <= 9'h000;
        end else begin
            coil_a_current  <= next_a;
            coil_b_current  <= next_b;
            table_index     <= next_idx;
            coil_b_position <= next_bpos;
        end
    end

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence write_addr_s(logic [7:0] idx);
        hsel && hready && htrans == 2'b10 && hwrite && hsize == 3'h2
            && haddr == {22'h0, idx, 2'h0};
    endsequence

    sequence read_addr_s(logic [7:0] idx);
        hsel && hready && htrans == 2'b10 && !hwrite && hsize == 3'h2
            && haddr == {22'h0, idx, 2'h0};
    endsequence

    sel_write_a: assert property (
        write_addr_s(8'h89) ##1 1'b1 |=> segment_width_config == $past(hwdata))
        else $error("segment register missed a write");

    sel_read_a: assert property (
        read_addr_s(8'h89) |=> hreadyout && hrdata == ($past(wr_pend) && $past(wr_reg) == MWT_R_SEL
            ? $past(hwdata) : $past(segment_width_config)))
        else $error("segment register read back wrong");

    start_mask_a: assert property (
        write_addr_s(8'h88) ##1 1'b1 |=> wave_start_values[15:8] == 8'h00)
        else $error("reserved start bits not zero");

    restart_load_a: assert property (
        restart |=> table_index == 9'h000
            && coil_a_current == $past(wave_start_values[7:0])
            && coil_b_current == $past(wave_start_values[23:16]))
        else $error("restart did not load start currents");

    step_accum_a: assert property (
        !restart && step_advance && table_index != 9'h100
            |=> table_index == $past(table_index) + 9'h001
            && coil_a_current == 8'($past(coil_a_current) + {{5{$past(a_delta[2])}}, $past(a_delta)}))
        else $error("coil a did not take the decoded step");

    step_b_a: assert property (
        !restart && step_advance && table_index != 9'h100
            |=> coil_b_current == 8'($past(coil_b_current) - {{5{$past(b_delta[2])}}, $past(b_delta)}))
        else $error("coil b did not take the decoded step");

    hold_idle_a: assert property (
        !restart && (!step_advance || table_index == 9'h100)
            |=> $stable(coil_a_current) && $stable(coil_b_current) && $stable(table_index))
        else $error("walker moved without a step");

    seg_first_a: assert property (
        a_ent < segment_width_config[15:8] |-> a_delta ==
            3'({1'b0, segment_width_config[1:0]}) - 3'h1 + 3'({2'h0, table_bits[a_ent]}))
        else $error("segment zero width not applied");

    zero_bit_a: assert property (
        a_ent < segment_width_config[15:8] && segment_width_config[1:0] == 2'b00
            && !table_bits[a_ent] |-> a_delta == 3'b111)
        else $error("zero bit with width 00 not minus one");

    one_bit_a: assert property (
        a_ent < segment_width_config[15:8] && segment_width_config[1:0] == 2'b11
            && table_bits[a_ent] |-> a_delta == 3'b011)
        else $error("one bit with width 11 not plus three");

    seg_second_a: assert property (
        segment_width_config[15:8] != 8'h00 && a_ent >= segment_width_config[15:8]
            && a_ent < segment_width_config[23:16] |-> a_delta ==
            3'({1'b0, segment_width_config[3:2]}) - 3'h1 + 3'({2'h0, table_bits[a_ent]}))
        else $error("segment one width not applied");

    seg_last_a: assert property (
        segment_width_config[15:8] != 8'h00
            && segment_width_config[23:16] > segment_width_config[15:8]
            && segment_width_config[31:24] > segment_width_config[23:16]
            && a_ent >= segment_width_config[31:24] |-> a_delta ==
            3'({1'b0, segment_width_config[7:6]}) - 3'h1 + 3'({2'h0, table_bits[a_ent]}))
        else $error("segment three width not applied");

    b_offset_a: assert property (
        1'b1 |=> coil_b_position == 9'(table_index
            + {$past(wave_start_values[31]), $past(wave_start_values[31:24])}))
        else $error("coil b offset wrong");

endmodule : mwt_wave_table
`default_nettype wire

/* File: src/mwt_consts.svh */
/*
 * register indices, byte addresses, reset values, field positions
 * of the microstep wave table block.
 * assumes: included by its bare name in the module and the bench files.
 */
`ifndef MWT_CONSTS_SVH
`define MWT_CONSTS_SVH

// ************************************************************
// register indices and byte addresses
// ************************************************************
`define MWT_IDX_SIX      8'h86
`define MWT_IDX_SEVEN    8'h87
`define MWT_IDX_START    8'h88
`define MWT_IDX_SEL      8'h89
`define MWT_ADDR_SIX     32'h0000_0218
`define MWT_ADDR_SEVEN   32'h0000_021C
`define MWT_ADDR_START   32'h0000_0220
`define MWT_ADDR_SEL     32'h0000_0224

// ************************************************************
// reset values
// ************************************************************
`define MWT_RST_SIX      32'h4929_5556
`define MWT_RST_SEVEN    32'h0040_4222
`define MWT_RST_START    32'h00F7_0000
`define MWT_RST_SEL      32'hFFFF_8056
`define MWT_START_MASK   32'hFFFF_00FF
`define MWT_RST_COIL_A   8'h00
`define MWT_RST_COIL_B   8'hF7

// ************************************************************
// field positions
// ************************************************************
`define MWT_START_A_LSB  0
`define MWT_START_B_LSB  16
`define MWT_OFFSET_LSB   24
`define MWT_BND1_LSB     8
`define MWT_BND2_LSB     16
`define MWT_BND3_LSB     24
`define MWT_W0_LSB       0
`define MWT_W1_LSB       2
`define MWT_W2_LSB       4
`define MWT_W3_LSB       6
`define MWT_LAST_POS     9'h100
`define MWT_HSIZE_WORD   3'h2

`endif

/* File: src/mwt_pkg.sv */
/*
 * types of the microstep wave table block.
 * assumes: mwt_consts.svh sits on the include path.
 */
package mwt_pkg;

    typedef logic [7:0] mwt_cur_t;
    typedef logic [1:0] mwt_width_t;
    typedef logic [8:0] mwt_pos_t;

    typedef enum logic [2:0] {
        MWT_R_NONE  = 3'b000,
        MWT_R_SIX   = 3'b001,
        MWT_R_SEVEN = 3'b010,
        MWT_R_START = 3'b011,
        MWT_R_SEL   = 3'b100
    } mwt_reg_t;

endpackage : mwt_pkg

/* File: verif/mwt_wave_table_bench.sv */
/* bench of mwt_wave_table: ahb-lite register access, coil walks.
   assumes: mwt_pkg compiled first, mwt_consts.svh on include path. */
`timescale 1ns/1ps
`default_nettype none
`include "mwt_consts.svh"
module mwt_wave_table_bench;
    import mwt_pkg::*;
    // ****
    // signals and model state
    // ****
    logic         hclk;
    logic         hresetn;
    logic         hsel;
    logic [31:0]  haddr;
    logic [1:0]   htrans;
    logic         hwrite;
    logic [2:0]   hsize;
    logic [31:0]  hwdata;
    logic         hready;
    logic         hreadyout;
    logic         hresp;
    logic [31:0]  hrdata;
    logic [191:0] lower_delta_bits;
    logic         step_advance;
    logic         restart;
    mwt_cur_t     coil_a_current;
    mwt_cur_t     coil_b_current;
    mwt_pos_t     table_index;
    mwt_pos_t     coil_b_position;
    logic [31:0]  six_m;
    logic [31:0]  seven_m;
    logic [31:0]  start_m;
    logic [31:0]  sel_m;
    logic [31:0]  rdat;
    logic [31:0]  adr [4];
    logic [7:0]   b1;
    logic [7:0]   b2;
    logic [7:0]   b3;
    integer       seed;
    int           bad_count;
    int           n_compared;

    assign hready = hreadyout;

    mwt_wave_table dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .lower_delta_bits(lower_delta_bits), .step_advance(step_advance), .restart(restart),
        .coil_a_current(coil_a_current), .coil_b_current(coil_b_current),
        .table_index(table_index), .coil_b_position(coil_b_position)
    );

    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    // ****
    // tasks and functions
    // ****
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        n_compared++;
        if (seen !== want) begin
            bad_count++;
            $display("ERROR %s expected %h seen %h", what, want, seen);
        end
    endtask : check

    task automatic close_out();
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : close_out

    task automatic wait_ready();
        int t;
        t = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            t++;
            if (t > 50) begin
                bad_count++;
                close_out();
            end
            @(posedge hclk);
        end
    endtask : wait_ready

    task automatic xfer(input logic wr, input logic [31:0] a, input logic [2:0] sz,
                        input logic [31:0] wd, output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        hsize  <= sz;
        wait_ready();
        htrans <= 2'b00;
        hsel   <= 1'b0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        check("hresp", {31'h0, hresp}, 32'h0);
    endtask : xfer

    function automatic logic [31:0] reg_m(input logic [31:0] a);
        case (a)
            `MWT_ADDR_SIX:   return six_m;
            `MWT_ADDR_SEVEN: return seven_m;
            `MWT_ADDR_START: return start_m;
            default:         return sel_m;
        endcase
    endfunction : reg_m

    task automatic put(input logic [31:0] a, input logic [31:0] d);
        xfer(1'b1, a, `MWT_HSIZE_WORD, d, rdat);
        case (a)
            `MWT_ADDR_SIX:   six_m = d;
            `MWT_ADDR_SEVEN: seven_m = d;
            `MWT_ADDR_START: start_m = d & 32'hFFFF_00FF;
            default:         sel_m = d;
        endcase
    endtask : put

    task automatic get(input string what, input logic [31:0] a, input logic [31:0] want);
        xfer(1'b0, a, `MWT_HSIZE_WORD, 32'h0, rdat);
        check(what, rdat, want);
    endtask : get

    // step of entry n from its bit and its segment's width
    function automatic int dlt(input int n);
        logic [255:0] bits;
        logic [1:0]   w;
        bits = {seven_m, six_m, lower_delta_bits};
        if (n < sel_m[15:8])
            w = sel_m[1:0];
        else if (n < sel_m[23:16])
            w = sel_m[3:2];
        else if (n < sel_m[31:24])
            w = sel_m[5:4];
        else
            w = sel_m[7:6];
        return int'(w) - 1 + int'(bits[n]);
    endfunction : dlt

    task automatic walk(input int steps, input logic hold_step);
        logic [7:0] ea;
        logic [7:0] eb;
        logic [8:0] idx;
        @(posedge hclk);
        restart      <= 1'b1;
        step_advance <= hold_step;
        @(posedge hclk);
        restart      <= 1'b0;
        step_advance <= 1'b1;
        ea  = start_m[7:0];
        eb  = start_m[23:16];
        idx = 9'h0;
        for (int i = 0; i <= steps; i++) begin
            if (i > 0) begin
                @(posedge hclk);
                if (i == steps)
                    step_advance <= 1'b0;
                if (idx != 9'h100) begin
                    ea  = ea + 8'(dlt(int'(idx)));
                    eb  = eb - 8'(dlt(255 - int'(idx)));
                    idx = idx + 9'h1;
                end
            end
            #1;
            check("index", {23'h0, table_index}, {23'h0, idx});
            check("coil_a", {24'h0, coil_a_current}, {24'h0, ea});
            check("coil_b", {24'h0, coil_b_current}, {24'h0, eb});
            check("pos", {23'h0, coil_b_position}, {23'h0, idx + {start_m[31], start_m[31:24]}});
        end
    endtask : walk
    // ****
    // stimulus
    // ****
    initial begin
        seed = 21086;
        {hsel, hwrite, step_advance, restart, hresetn} = 5'h0;
        {haddr, hwdata, htrans, hsize} = 69'h0;
        lower_delta_bits = 192'h0;
        bad_count = 0;
        n_compared = 0;
        adr = '{`MWT_ADDR_SIX, `MWT_ADDR_SEVEN, `MWT_ADDR_START, `MWT_ADDR_SEL};
        six_m = 32'h4929_5556;
        seven_m = 32'h0040_4222;
        start_m = 32'h00F7_0000;
        sel_m = 32'hFFFF_8056;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        #1;
        check("coil_a", {24'h0, coil_a_current}, 32'h0);
        check("coil_b", {24'h0, coil_b_current}, 32'hF7);
        get("six", `MWT_ADDR_SIX, 32'h4929_5556);
        get("seven", `MWT_ADDR_SEVEN, 32'h0040_4222);
        get("start", `MWT_ADDR_START, 32'h00F7_0000);
        get("sel", `MWT_ADDR_SEL, 32'hFFFF_8056);
        check("widths", {24'h0, rdat[7:0]}, 32'h56);
        $display("test reset values done");
        xfer(1'b1, `MWT_ADDR_SEL, 3'h0, 32'h1234_5678, rdat);
        get("sel_sz", `MWT_ADDR_SEL, sel_m);
        get("unmapped", 32'h0000_0228, 32'h0);
        get("misalign", 32'h0000_0219, 32'h0);
        for (int i = 0; i < 16; i++) begin
            put(adr[i % 4], $random(seed));
            get("readback", adr[i % 4], reg_m(adr[i % 4]));
        end
        $display("test register access done");
        for (int w = 0; w < 4; w++) begin
            b1 = 8'(1 + $unsigned($random(seed)) % 80);
            b2 = b1 + 8'(1 + $unsigned($random(seed)) % 80);
            b3 = b2 + 8'(1 + $unsigned($random(seed)) % 80);
            // every width code lands once in every segment
            put(`MWT_ADDR_SEL, {b3, b2, b1, 2'(w + 3), 2'(w + 2), 2'(w + 1), 2'(w)});
            put(`MWT_ADDR_START, $random(seed));
            put(`MWT_ADDR_SIX, $random(seed));
            put(`MWT_ADDR_SEVEN, $random(seed));
            lower_delta_bits <= {$random(seed), $random(seed), $random(seed),
                                 $random(seed), $random(seed), $random(seed)};
            walk(257, w[0]);
            $display("test walk %0d done", w);
        end
        // reset in mid-run brings registers and walker back
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        #1;
        check("idx_rst", {23'h0, table_index}, 32'h0);
        check("coil_b_rst", {24'h0, coil_b_current}, 32'hF7);
        get("start_rst", `MWT_ADDR_START, `MWT_RST_START);
        get("sel_rst", `MWT_ADDR_SEL, `MWT_RST_SEL);
        $display("test mid-run reset done");
        close_out();
    end
endmodule : mwt_wave_table_bench
`default_nettype wire
